// ### logic/rifu_map.svh
/*
  register offsets, field positions, reset values and timing counts of the
  interrupt flag unit.
  assumes: included by bare name from the package and the design modules.
*/
`ifndef RIFU_MAP_SVH
`define RIFU_MAP_SVH

// ----------------------------------------------------------------------------
// register map
// ----------------------------------------------------------------------------
`define RIFU_ADDR_W 17
`define RIFU_OFS_STATUS_FLAGS 17'h1FFF0
`define RIFU_OFS_IRQ_CONTROL 17'h1FFF6

// ----------------------------------------------------------------------------
// irq_control fields
// ----------------------------------------------------------------------------
`define RIFU_CTL_WDOG_IE 7
`define RIFU_CTL_ALARM_IE 6
`define RIFU_CTL_PWR_IE 5
`define RIFU_CTL_HIGH 3
`define RIFU_CTL_PULSE 2
`define RIFU_CTL_WMASK 8'hEC
`define RIFU_CTL_RESET 8'h00
`define RIFU_CTL_NOBAT_RESET 8'h24

// ----------------------------------------------------------------------------
// status_flags fields
// ----------------------------------------------------------------------------
`define RIFU_FLG_WDOG 7
`define RIFU_FLG_ALARM 6
`define RIFU_FLG_PWR 5
`define RIFU_FLG_OSC 4
`define RIFU_FLG_FTEST 2
`define RIFU_FLG_UPD_W 1
`define RIFU_FLG_UPD_R 0
`define RIFU_FLG_WMASK 8'h07
`define RIFU_FLG_RESET 8'h00

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define RIFU_CLK_HZ 100000000
`define RIFU_SLOW_HZ 1000
`define RIFU_PULSE_MS 200
`define RIFU_SLOW_DIV (`RIFU_CLK_HZ / `RIFU_SLOW_HZ)
`define RIFU_PULSE_TICKS (`RIFU_PULSE_MS * `RIFU_SLOW_HZ / 1000)

`endif

// ### logic/rifu_pkg.sv
/*
  types shared by the interrupt flag unit modules.
  assumes: nothing beyond the map header.
*/
`include "rifu_map.svh"

package rifu_pkg;

  typedef logic [7:0] rifu_byte_t;

  typedef enum logic [1:0] {
    RIFU_IDLE,
    RIFU_READ,
    RIFU_PULSE,
    RIFU_LEVEL
  } rifu_drv_e;

endpackage

// ### logic/rifu_tick_if.sv
/*
  carries the pulse timer start, stop and running handshake between top and timer.
  assumes: one clock domain.
*/
`timescale 1ns/100ps

interface rifu_tick_if;
  logic start;
  logic stop;
  logic running;
  modport top (output start, output stop, input running);
  modport timer (input start, input stop, output running);
endinterface

// ### logic/rifu_pulse_timer.sv
/*
  one-shot pulse timer: divides the clock to a slow tick and counts the
  pulse width in slow ticks.
  assumes: start and stop are one-cycle pulses from the top module.
*/
`timescale 1ns/100ps

`include "rifu_map.svh"

module rifu_pulse_timer
  import rifu_pkg::*;
#(
  parameter int DIV = `RIFU_SLOW_DIV,
  parameter int TICKS = `RIFU_PULSE_TICKS
) (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  rifu_tick_if.timer tick
);

  typedef struct packed {
    logic [31:0] div_cnt;
    logic [31:0] tick_cnt;
    logic running;
  } rifu_tmr_s;

  rifu_tmr_s q;
  rifu_tmr_s next_q;

  // --------------------------------------------------------------------------
  // slow tick and width count
  // --------------------------------------------------------------------------
  always_comb begin
    next_q = q;
    if (q.div_cnt == 32'(DIV - 1)) begin
      next_q.div_cnt = 32'h0000_0000;
    end else begin
      next_q.div_cnt = q.div_cnt + 32'h0000_0001;
    end
    if (q.running && q.div_cnt == 32'(DIV - 1)) begin
      if (q.tick_cnt == 32'(TICKS - 1)) begin
        next_q.running = 1'b0;
      end else begin
        next_q.tick_cnt = q.tick_cnt + 32'h0000_0001;
      end
    end
    if (tick.start) begin
      next_q.running = 1'b1;
      next_q.tick_cnt = 32'h0000_0000;
      next_q.div_cnt = 32'h0000_0000;
    end
    if (tick.stop) begin
      next_q.running = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign tick.running = q.running;

endmodule // rifu_pulse_timer

// ### logic/rifu_event_edge.sv
/*
  rising-edge detector for one interrupt source event line.
  assumes: source is synchronous to the clock.
*/
`timescale 1ns/100ps

module rifu_event_edge (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic src_in,
  output logic rise_out
);

  logic prev;

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      prev <= 1'b0;
    end else begin
      prev <= src_in;
    end
  end

  assign rise_out = src_in & ~prev;

endmodule // rifu_event_edge

// ### logic/rifu_irq_unit.sv
/*
  interrupt flag unit: three sticky source flags, irq_control register and
  the shared interrupt pin driver with push-pull/open-drain and pulse/level.
  assumes: asynchronous memory bus pins already sampled into ref_clk_in;
  chip enable, output enable and write enable are active low.
*/
// Contract
// - three sources, each with own enable and own flag
// - pin active when any flagged source has its enable set
// - flags clear after the read cycle ends, write strobe high
// - watchdog timeout sets flag; drives pin only when enabled
// - alarm match sets flag; drives pin only when enabled
// - power fail sets flag; drives pin only when enabled
// - polarity 1 push-pull high when supply good; 0 open-drain low
// - in backup only open-drain low may drive, for alarm; code lets any enabled source drive it
// - pulse mode gives a fixed pulse of about 200 ms; code restarts it on each new enabled event
// - level mode holds pin active until flags are read
// - reading flags in pulse mode ends the pulse early
// - control resets to 00h, or 24h on power-on without battery
// - flags start at zero, each set by its own event
// - control layout: wdog, alarm, power enables, 0, high, pulse, 0, 0
// - flags layout: wdog, alarm, power, osc, 0, ftest, two update bits
// - alarm match event sets the alarm flag
// - watchdog reaching zero raises the timeout event
`timescale 1ns/100ps

`include "rifu_map.svh"

module rifu_irq_unit
  import rifu_pkg::*;
#(
  parameter int PULSE_DIV = `RIFU_SLOW_DIV,
  parameter int PULSE_TICKS = `RIFU_PULSE_TICKS
) (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic no_battery_in,
  input wire logic [16:0] addr_in,
  input wire logic [7:0] data_in,
  input wire logic chip_en_b_in,
  input wire logic out_en_b_in,
  input wire logic write_en_b_in,
  input wire logic watchdog_zero_in,
  input wire logic alarm_hit_in,
  input wire logic power_fail_in,
  input wire logic osc_failed_in,
  input wire logic supply_good_in,
  output logic [7:0] data_out,
  output logic data_oe_out,
  output logic irq_pin_out,
  output logic irq_pin_oe_out
);

  typedef struct packed {
    rifu_byte_t ctl;
    logic wdog_flag;
    logic alarm_flag;
    logic pwr_flag;
    logic osc_flag;
    logic [2:0] low_bits;
    rifu_drv_e drv;
    logic rd_flags;
    logic rd_flags_q;
    logic wr_prev;
    rifu_byte_t dout;
    logic dout_oe;
    logic pin;
    logic pin_oe;
    logic first;
  } rifu_top_s;

  rifu_top_s q;
  rifu_top_s next_q;

  rifu_tick_if tick ();

  logic wdog_rise;
  logic alarm_rise;
  logic pwr_rise;
  logic flags_sel;
  logic ctl_sel;
  logic wr_act;
  logic rd_act;
  logic wdog_set;
  logic alarm_set;
  logic pwr_set;
  logic irq_req;
  logic new_irq;
  logic read_done;
  logic active;

  // --------------------------------------------------------------------------
  // source events
  // --------------------------------------------------------------------------
  // watchdog terminal count
  rifu_event_edge u_wdog_edge (
    .ref_clk_in(ref_clk_in),
    .rst_b_in(rst_b_in),
    .src_in(watchdog_zero_in),
    .rise_out(wdog_rise)
  );

  rifu_event_edge u_alarm_edge (
    .ref_clk_in(ref_clk_in),
    .rst_b_in(rst_b_in),
    .src_in(alarm_hit_in),
    .rise_out(alarm_rise)
  );

  rifu_event_edge u_pwr_edge (
    .ref_clk_in(ref_clk_in),
    .rst_b_in(rst_b_in),
    .src_in(power_fail_in),
    .rise_out(pwr_rise)
  );

  rifu_pulse_timer #(
    .DIV(PULSE_DIV),
    .TICKS(PULSE_TICKS)
  ) u_timer (
    .ref_clk_in(ref_clk_in),
    .rst_b_in(rst_b_in),
    .tick(tick.timer)
  );

  // --------------------------------------------------------------------------
  // bus decode
  // --------------------------------------------------------------------------
  assign flags_sel = (addr_in == `RIFU_OFS_STATUS_FLAGS);
  assign ctl_sel = (addr_in == `RIFU_OFS_IRQ_CONTROL);
  assign wr_act = !chip_en_b_in && !write_en_b_in;
  assign rd_act = !chip_en_b_in && !out_en_b_in && write_en_b_in;

  // --------------------------------------------------------------------------
  // flag sources and interrupt request
  // --------------------------------------------------------------------------
  // one set term per source
  assign wdog_set = wdog_rise;
  assign alarm_set = alarm_rise;
  assign pwr_set = pwr_rise;

  // --------------------------------------------------------------------------
  // interrupt request
  // --------------------------------------------------------------------------
  // or of flag and enable terms
  assign irq_req = (q.wdog_flag & q.ctl[`RIFU_CTL_WDOG_IE])
    | (q.alarm_flag & q.ctl[`RIFU_CTL_ALARM_IE])
    | (q.pwr_flag & q.ctl[`RIFU_CTL_PWR_IE]);

  assign new_irq = (wdog_set & q.ctl[`RIFU_CTL_WDOG_IE])
    | (alarm_set & q.ctl[`RIFU_CTL_ALARM_IE])
    | (pwr_set & q.ctl[`RIFU_CTL_PWR_IE]);

  // --------------------------------------------------------------------------
  // read end and pulse timer control
  // --------------------------------------------------------------------------
  // clear after read cycle ends
  assign read_done = q.rd_flags && !(rd_act && flags_sel);

  // timer runs in pulse mode only
  assign tick.start = new_irq && q.ctl[`RIFU_CTL_PULSE];
  assign tick.stop = read_done;

  always_comb begin
    next_q = q;
    next_q.first = 1'b0;
    next_q.wr_prev = wr_act;

    // ------------------------------------------------------------------------
    // control register
    // ------------------------------------------------------------------------
    // strap caught after reset release
    if (q.first && no_battery_in) begin
      next_q.ctl = `RIFU_CTL_NOBAT_RESET;
    end
    if (wr_act && ctl_sel) begin
      next_q.ctl = data_in & `RIFU_CTL_WMASK;
    end

    // ------------------------------------------------------------------------
    // status flags
    // ------------------------------------------------------------------------
    if (wr_act && flags_sel) begin
      next_q.low_bits = data_in[2:0] & 3'(`RIFU_FLG_WMASK);
    end
    next_q.rd_flags = rd_act && flags_sel;
    next_q.rd_flags_q = q.rd_flags;
    if (read_done) begin
      next_q.wdog_flag = 1'b0;
      next_q.alarm_flag = 1'b0;
      next_q.pwr_flag = 1'b0;
      next_q.osc_flag = 1'b0;
    end
    // each flag set by its event, set wins
    if (wdog_set) begin
      next_q.wdog_flag = 1'b1;
    end
    if (alarm_set) begin
      next_q.alarm_flag = 1'b1;
    end
    if (pwr_set) begin
      next_q.pwr_flag = 1'b1;
    end
    if (osc_failed_in) begin
      next_q.osc_flag = 1'b1;
    end

    // ------------------------------------------------------------------------
    // read data
    // ------------------------------------------------------------------------
    // flags read layout
    next_q.dout = 8'h00;
    next_q.dout_oe = rd_act && (flags_sel || ctl_sel);
    if (rd_act && flags_sel) begin
      next_q.dout[`RIFU_FLG_WDOG] = q.wdog_flag;
      next_q.dout[`RIFU_FLG_ALARM] = q.alarm_flag;
      next_q.dout[`RIFU_FLG_PWR] = q.pwr_flag;
      next_q.dout[`RIFU_FLG_OSC] = q.osc_flag;
      next_q.dout[`RIFU_FLG_FTEST] = q.low_bits[`RIFU_FLG_FTEST];
      next_q.dout[`RIFU_FLG_UPD_W] = q.low_bits[`RIFU_FLG_UPD_W];
      next_q.dout[`RIFU_FLG_UPD_R] = q.low_bits[`RIFU_FLG_UPD_R];
    end else if (rd_act && ctl_sel) begin
      next_q.dout = q.ctl;
    end

    // ------------------------------------------------------------------------
    // pin driver state
    // ------------------------------------------------------------------------
    unique case (q.drv)
      RIFU_IDLE: begin
        if (q.ctl[`RIFU_CTL_PULSE] && new_irq) begin
          next_q.drv = RIFU_PULSE;
        end else if (!q.ctl[`RIFU_CTL_PULSE] && irq_req) begin
          next_q.drv = RIFU_LEVEL;
        end
      end
      RIFU_READ: begin
        next_q.drv = RIFU_IDLE;
      end
      RIFU_PULSE: begin
        if (read_done || (!tick.running && !tick.start)) begin
          next_q.drv = RIFU_READ;
        end
      end
      RIFU_LEVEL: begin
        if (read_done) begin
          next_q.drv = RIFU_READ;
        end
      end
    endcase

    // ------------------------------------------------------------------------
    // pin output
    // ------------------------------------------------------------------------
    active = (q.drv == RIFU_PULSE) || (q.drv == RIFU_LEVEL);
    if (q.ctl[`RIFU_CTL_HIGH]) begin
      next_q.pin = active && supply_good_in;
      next_q.pin_oe = supply_good_in;
    end else begin
      next_q.pin = 1'b0;
      next_q.pin_oe = active;
    end
  end

  // --------------------------------------------------------------------------
  // state register
  // --------------------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      q <= '0;
      q.ctl <= `RIFU_CTL_RESET;
      q.first <= 1'b1;
      q.drv <= RIFU_IDLE;
    end else begin
      q <= next_q;
    end
  end

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  assign data_out = q.dout;
  assign data_oe_out = q.dout_oe;
  assign irq_pin_out = q.pin;
  assign irq_pin_oe_out = q.pin_oe;

endmodule // rifu_irq_unit

// ### tb/rifu_irq_unit_assertions.sv
/*
  pin-level assertions on the interrupt flag unit.
  assumes: bound to rifu_irq_unit; control writes seen on its bus pins.
*/
`timescale 1ns/100ps
`include "rifu_map.svh"

module rifu_irq_chk #(
  parameter int PULSE_DIV = 4,
  parameter int PULSE_TICKS = 5
) (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic no_battery_in,
  input wire logic [16:0] addr_in,
  input wire logic [7:0] data_in,
  input wire logic chip_en_b_in,
  input wire logic out_en_b_in,
  input wire logic write_en_b_in,
  input wire logic watchdog_zero_in,
  input wire logic alarm_hit_in,
  input wire logic power_fail_in,
  input wire logic supply_good_in,
  input wire logic [7:0] data_out,
  input wire logic data_oe_out,
  input wire logic irq_pin_out,
  input wire logic irq_pin_oe_out
);
  logic [7:0] ctl;
  logic first;
  logic rd_q;
  logic src_q;
  int run;
  wire rd = !chip_en_b_in && !out_en_b_in && write_en_b_in;
  wire src = watchdog_zero_in | alarm_hit_in | power_fail_in;
  wire mapped = addr_in == `RIFU_OFS_STATUS_FLAGS || addr_in == `RIFU_OFS_IRQ_CONTROL;
  // pin asserted in its programmed polarity
  wire pin_act = ctl[3] ? irq_pin_out : irq_pin_oe_out;

  // ----
  // mirror of the control register and pin run length
  // ----
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      ctl <= 8'h00;
      first <= 1'b1;
      rd_q <= 1'b0;
      src_q <= 1'b0;
      run <= 0;
    end else begin
      first <= 1'b0;
      if (first && no_battery_in) begin
        ctl <= 8'h24;
      end else if (!chip_en_b_in && !write_en_b_in && addr_in == `RIFU_OFS_IRQ_CONTROL) begin
        ctl <= data_in & `RIFU_CTL_WMASK;
      end
      rd_q <= rd && addr_in == `RIFU_OFS_STATUS_FLAGS;
      src_q <= src;
      // a new source event restarts the pulse width
      run <= !pin_act ? 0 : (src && !src_q) ? 1 : run + 1;
    end
  end

  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);

  reset_vals_a: assert property (
    $rose(rst_b_in) |-> !data_oe_out && !irq_pin_oe_out && data_out == 8'h00) else $error("outputs not idle");
  unmapped_quiet_a: assert property (
    rd && !chip_en_b_in && !mapped |=> !data_oe_out && data_out == 8'h00) else $error("unmapped read answered");
  open_drain_a: assert property (
    !ctl[3] [*2] |-> !irq_pin_out) else $error("open drain drove high");
  push_pull_off_a: assert property (
    (ctl[3] && !supply_good_in) [*2] |-> !irq_pin_oe_out) else $error("push pull drove in backup");
  quiet_pin_a: assert property (
    (ctl[7:5] == 3'b000 && !ctl[2] && !ctl[3]) [*3] |-> !irq_pin_oe_out) else $error("pin active, no enable");
  level_raise_a: assert property (
    !ctl[3] && !ctl[2] && ctl[7] && $rose(watchdog_zero_in) |-> ##[1:4] irq_pin_oe_out) else $error("no level irq");
  read_release_a: assert property (
    !ctl[3] && rd_q && !rd && !src |-> ##[1:3] !irq_pin_oe_out) else $error("pin held after read");
  pulse_width_a: assert property (
    ctl[2] |-> run <= PULSE_TICKS * PULSE_DIV + PULSE_DIV + 4) else $error("pulse too long");
endmodule // rifu_irq_chk

bind rifu_irq_unit rifu_irq_chk #(.PULSE_DIV(PULSE_DIV), .PULSE_TICKS(PULSE_TICKS)) chk (
  .ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .no_battery_in(no_battery_in), .addr_in(addr_in),
  .data_in(data_in), .chip_en_b_in(chip_en_b_in), .out_en_b_in(out_en_b_in), .write_en_b_in(write_en_b_in),
  .watchdog_zero_in(watchdog_zero_in), .alarm_hit_in(alarm_hit_in), .power_fail_in(power_fail_in),
  .supply_good_in(supply_good_in), .data_out(data_out), .data_oe_out(data_oe_out),
  .irq_pin_out(irq_pin_out), .irq_pin_oe_out(irq_pin_oe_out));

// ### tb/rifu_host_model.sv
/*
  host processor model: byte cycles on the memory bus pins and the
  interrupt wire seen through its pull-up.
  assumes: tasks are called by the bench, one at a time.
*/
`timescale 1ns/100ps

module rifu_host_model (
  input wire logic clk_in,
  input wire logic [7:0] rdata_in,
  input wire logic rdata_oe_in,
  input wire logic irq_in,
  input wire logic irq_oe_in,
  output logic [16:0] addr_out,
  output logic [7:0] wdata_out,
  output logic ce_b_out,
  output logic oe_b_out,
  output logic we_b_out,
  output logic irq_wire_out
);
  // open-drain wire floats to the pull-up
  assign irq_wire_out = irq_oe_in ? irq_in : 1'b1;

  initial begin
    addr_out = 17'h00000;
    wdata_out = 8'h00;
    ce_b_out = 1'b1;
    oe_b_out = 1'b1;
    we_b_out = 1'b1;
  end

  task automatic wr(input logic [16:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_out <= a;
    wdata_out <= d;
    ce_b_out <= 1'b0;
    we_b_out <= 1'b0;
    @(posedge clk_in);
    ce_b_out <= 1'b1;
    we_b_out <= 1'b1;
    wdata_out <= ~d;
  endtask

  task automatic rd(input logic [16:0] a, output logic [7:0] d, output logic v);
    @(posedge clk_in);
    addr_out <= a;
    ce_b_out <= 1'b0;
    oe_b_out <= 1'b0;
    repeat (2) @(posedge clk_in);
    #1;
    d = rdata_in;
    v = rdata_oe_in;
    @(posedge clk_in);
    ce_b_out <= 1'b1;
    oe_b_out <= 1'b1;
    addr_out <= ~a;
  endtask
endmodule // rifu_host_model

// ### tb/rifu_irq_unit_bench.sv
/*
  self-checking bench for the interrupt flag unit.
  assumes: short pulse timer parameters; host model on the bus.
*/
`timescale 1ns/100ps
`include "rifu_map.svh"

module rifu_irq_unit_bench;
  localparam logic [16:0] CA = `RIFU_OFS_IRQ_CONTROL;
  localparam logic [16:0] FA = `RIFU_OFS_STATUS_FLAGS;
  logic clk, rst_b, nb, wdz, alm, pwf, osc, sg;
  wire [16:0] addr;
  wire [7:0] wd, dout;
  wire ce_b, oe_b, we_b, doe, pin, pin_oe, irqw;
  int errors, n_tests, mflags, mctl, r;
  logic [7:0] d;
  logic v;

  rifu_irq_unit #(.PULSE_DIV(4), .PULSE_TICKS(5)) dut (.ref_clk_in(clk), .rst_b_in(rst_b),
    .no_battery_in(nb), .addr_in(addr), .data_in(wd), .chip_en_b_in(ce_b), .out_en_b_in(oe_b),
    .write_en_b_in(we_b), .watchdog_zero_in(wdz), .alarm_hit_in(alm), .power_fail_in(pwf),
    .osc_failed_in(osc), .supply_good_in(sg), .data_out(dout), .data_oe_out(doe),
    .irq_pin_out(pin), .irq_pin_oe_out(pin_oe));
  rifu_host_model host (.clk_in(clk), .rdata_in(dout), .rdata_oe_in(doe), .irq_in(pin),
    .irq_oe_in(pin_oe), .addr_out(addr), .wdata_out(wd), .ce_b_out(ce_b), .oe_b_out(oe_b),
    .we_b_out(we_b), .irq_wire_out(irqw));

  // ----
  // checking tasks
  // ----
  task chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task reg_rd(input logic [16:0] a, input logic [7:0] exp);
    host.rd(a, d, v);
    chk(d, exp, "read data");
    chk({7'h00, v}, {7'h00, a == CA || a == FA}, "read enable");
    if (a == FA) begin
      mflags &= 8'h07;
      repeat (3) @(posedge clk);
    end
  endtask

  task pin_chk(input bit act);
    logic eo, ep;
    #1;
    eo = mctl[3] ? sg : act;
    ep = mctl[3] & act & sg;
    chk({5'h00, pin_oe, pin, irqw}, {5'h00, eo, ep, eo ? ep : 1'b1}, "pin");
  endtask

  task reset(input bit b);
    rst_b <= 1'b0;
    nb <= b;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    mctl = b ? 8'h24 : 8'h00;
    mflags = 0;
    repeat (2) @(posedge clk);
  endtask

  task fire(input int k);
    @(posedge clk);
    wdz <= k == 0;
    alm <= k == 1;
    pwf <= k == 2;
    @(posedge clk);
    {wdz, alm, pwf} <= 3'b000;
    mflags |= 8'h80 >> k;
  endtask

  task set_ctl(input int c);
    mctl = c;
    host.wr(CA, 8'(c));
  endtask

  task test_done;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    test_done;
  end

  // ----
  // tests
  // ----
  initial begin
    {rst_b, nb, wdz, alm, pwf, osc, sg} = 7'b0000001;
    errors = 0;
    n_tests = 0;
    r = $urandom(21839);
    reset(1);
    reg_rd(CA, 8'h24);
    reg_rd(FA, 8'h00);
    reset(0);
    reg_rd(CA, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      r = $urandom;
      set_ctl(r & 8'hEC);
      host.wr(CA, 8'(r));
      reg_rd(CA, 8'(mctl));
      host.wr(FA, 8'(r));
      reg_rd(FA, 8'(r & 7));
      host.wr(17'h1FFF1, 8'(r));
      reg_rd(17'h1FFF1, 8'h00);
    end
    host.wr(FA, 8'h00);
    $display("test registers done");
    for (int i = 0; i < 6; i++) begin
      set_ctl(i < 3 ? 8'h80 >> (i % 3) : 0);
      fire(i % 3);
      repeat (4) @(posedge clk);
      pin_chk(i < 3);
      reg_rd(FA, 8'(mflags));
      pin_chk(0);
    end
    $display("test sources done");
    set_ctl(8'h84);
    fire(0);
    repeat (4) @(posedge clk);
    pin_chk(1);
    repeat (8) @(posedge clk);
    fire(0);
    repeat (12) @(posedge clk);
    pin_chk(1);
    repeat (18) @(posedge clk);
    pin_chk(0);
    fire(0);
    repeat (4) @(posedge clk);
    reg_rd(FA, 8'h80);
    pin_chk(0);
    $display("test pulse done");
    set_ctl(8'h88);
    fire(0);
    repeat (4) @(posedge clk);
    pin_chk(1);
    @(posedge clk);
    sg <= 1'b0;
    repeat (3) @(posedge clk);
    pin_chk(1);
    reg_rd(FA, 8'h80);
    set_ctl(8'h40);
    fire(1);
    repeat (4) @(posedge clk);
    pin_chk(1);
    @(posedge clk);
    osc <= 1'b1;
    @(posedge clk);
    osc <= 1'b0;
    reg_rd(FA, 8'h50);
    pin_chk(0);
    sg <= 1'b1;
    $display("test polarity done");
    test_done;
  end
endmodule // rifu_irq_unit_bench
